/* rtl/dpsr_device.sv */
`timescale 1ns/1ns
// Operation
// - command bit 47 one means read, zero means write
// - command bit 46 zero selects array, one selects register space
// - command bit 45 gives burst type
// - array access may start after bits 47..16 arrive
// - third command word picks starting word within the row
// - device drives strobe through all command cycles
// - strobe low means one latency count, high means two
// - read data leaves edge-aligned with strobe toggles after latency
// - wrapped reads wrap within burst length, linear reads run sequentially
// - linear read past last address continues at address zero
// - chip select high ends any transfer, required between transactions
// - clock may stop, held idle while chip select high
// - write byte one on rising edge, byte two on falling edge
// - mask high leaves byte unchanged, mask low stores it
// - strobe released after command cycles, master drives low preamble
// - no extra latency signalled during write data
// - hybrid wrap wraps once then goes linear from next boundary
// - linear write past last address continues at address zero
// - zero-latency writes store whole words, device leaves strobe released
// - register words move high byte first for reads and writes
// - burst bit zero is wrapped, one is linear
// - latency count comes from bits 7..4 of first configuration register
module dpsr_device #(
  parameter int ARRAY_AW = 22,
  parameter logic [15:0] ID0_VALUE = 16'h1234,  // arbitrary value
  parameter logic [15:0] ID1_VALUE = 16'h0005   // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clock,
  input wire logic cs_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic read_write_data_strobe_in,
  output logic read_write_data_strobe_out,
  output logic read_write_data_strobe_oe,
  input wire logic refresh_busy,
  output logic arr_wr_valid,
  input wire logic arr_wr_ready,
  output logic [ARRAY_AW-1:0] arr_wr_addr,
  output logic [15:0] arr_wr_data,
  output logic [1:0] arr_wr_mask,
  output logic arr_rd_req,
  output logic [ARRAY_AW-1:0] arr_rd_addr,
  input wire logic arr_rd_valid,
  input wire logic [15:0] arr_rd_data,
  input wire logic overflow_clear,
  output logic wr_overflow,
  output logic busy,
  output logic [15:0] config_register_first,
  output logic [15:0] config_register_second
);
  localparam int BW = ARRAY_AW + 18;

  // ============================================================
  // pin synchronisers and link clock edge detection
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  logic lclk_prev_r;
  logic lclk_s;
  logic selected;
  logic read_write_data_strobe_s;
  logic [7:0] dq_s;
  logic rise;
  logic fall;
  logic edge_seen;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= dpsr_pkg::SYNC_RST;
      sync2_r <= dpsr_pkg::SYNC_RST;
    end else begin
      sync1_r <= {link_clock, cs_n, read_write_data_strobe_in, dq_in};
      sync2_r <= sync1_r;
    end
  end

  // previous link clock level
  always_ff @(posedge clk) begin
    if (rst) begin
      lclk_prev_r <= 1'b0;
    end else begin
      lclk_prev_r <= lclk_s;
    end
  end

  // edges count only while selected, so a clock running while deselected is harmless
  assign lclk_s = sync2_r[10];
  assign selected = ~sync2_r[9];
  assign read_write_data_strobe_s = sync2_r[8];
  assign dq_s = sync2_r[7:0];
  assign rise = selected & lclk_s & ~lclk_prev_r;
  assign fall = selected & ~lclk_s & lclk_prev_r;
  assign edge_seen = rise | fall;

  // ============================================================
  // transaction state and command capture
  dpsr_pkg::dpsr_state_type state_r;
  logic [2:0] edge_cnt_r;
  logic [39:0] ca_r;
  logic [31:0] row_r;
  logic [47:0] ca_full;
  logic ca_done;
  logic is_read_r;
  logic is_reg_r;
  logic linear_r;
  logic hybrid_r;
  logic lat_double_r;
  logic [4:0] lat_cnt_r;
  logic [4:0] lat_total;
  logic [3:0] lat_one;
  logic [1:0] reg_sel_r;
  logic [31:0] addr_full;
  logic [15:0] cfg0_r;
  logic [15:0] cfg1_r;
  logic [15:0] reg_word;

  assign ca_full = {ca_r, dq_s};
  assign ca_done = (state_r == dpsr_pkg::ST_CA) && edge_seen && (edge_cnt_r == dpsr_pkg::CA_LAST_EDGE);
  // row from the first two words, column from the third
  assign addr_full = {row_r[dpsr_pkg::ROW_W-1:0], ca_full[dpsr_pkg::CA_COL_W-1:0]};

  // latency from the configured count, doubled when strobe was high
  assign lat_one = (cfg0_r[dpsr_pkg::CFG_LAT_HI:dpsr_pkg::CFG_LAT_LO] == 4'h0) ? 4'h1 :
                   cfg0_r[dpsr_pkg::CFG_LAT_HI:dpsr_pkg::CFG_LAT_LO];
  assign lat_total = lat_double_r ? {lat_one, 1'b0} : {1'b0, lat_one};

  // register mux: id0, id1, cfg0, cfg1
  always_comb begin
    unique case ({row_r[dpsr_pkg::ROW_REG_SEL_BIT], ca_full[0]})
      2'b00: reg_word = ID0_VALUE;
      2'b01: reg_word = ID1_VALUE;
      2'b10: reg_word = cfg0_r;
      2'b11: reg_word = cfg1_r;
    endcase
  end

  // transaction sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dpsr_pkg::ST_IDLE;
    end else if (!selected) begin
      state_r <= dpsr_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        dpsr_pkg::ST_IDLE: state_r <= dpsr_pkg::ST_CA;
        dpsr_pkg::ST_CA: begin
          if (ca_done) begin
            // register writes carry no latency
            state_r <= (!ca_full[dpsr_pkg::CA_RW_BIT] && ca_full[dpsr_pkg::CA_SPACE_BIT]) ?
                       dpsr_pkg::ST_REGWR : dpsr_pkg::ST_LAT;
          end
        end
        dpsr_pkg::ST_LAT: begin
          if (fall && (lat_cnt_r + 5'h01 == lat_total)) begin
            state_r <= is_read_r ? dpsr_pkg::ST_RDATA : dpsr_pkg::ST_WDATA;
          end
        end
        dpsr_pkg::ST_REGWR: begin
          if (fall) begin
            state_r <= dpsr_pkg::ST_HOLD;
          end
        end
        dpsr_pkg::ST_RDATA, dpsr_pkg::ST_WDATA, dpsr_pkg::ST_HOLD: state_r <= state_r;
        default: state_r <= dpsr_pkg::ST_IDLE;
      endcase
    end
  end

  // command shift, edge and latency counters
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_cnt_r <= 3'h0;
      ca_r <= '0;
      row_r <= '0;
      lat_cnt_r <= 5'h00;
    end else begin
      if (state_r != dpsr_pkg::ST_CA) begin
        edge_cnt_r <= 3'h0;
      end else if (edge_seen) begin
        edge_cnt_r <= edge_cnt_r + 3'h1;
        ca_r <= {ca_r[31:0], dq_s};
        if (edge_cnt_r == dpsr_pkg::CA_ROW_EDGE) begin
          row_r <= {ca_r[23:0], dq_s};  // row usable before the third word
        end
      end
      if (state_r != dpsr_pkg::ST_LAT) begin
        lat_cnt_r <= 5'h00;
      end else if (fall) begin
        lat_cnt_r <= lat_cnt_r + 5'h01;
      end
    end
  end

  // transaction attributes
  always_ff @(posedge clk) begin
    if (rst) begin
      is_read_r <= 1'b0;
      is_reg_r <= 1'b0;
      hybrid_r <= 1'b0;
      lat_double_r <= 1'b0;
      reg_sel_r <= 2'b00;
    end else if (state_r == dpsr_pkg::ST_IDLE) begin
      lat_double_r <= refresh_busy | cfg0_r[dpsr_pkg::CFG_FIXED_BIT];
    end else if (ca_done) begin
      is_read_r <= ca_full[dpsr_pkg::CA_RW_BIT];
      is_reg_r <= ca_full[dpsr_pkg::CA_SPACE_BIT];
      hybrid_r <= cfg0_r[dpsr_pkg::CFG_HYBRID_BIT];
      reg_sel_r <= {row_r[dpsr_pkg::ROW_REG_SEL_BIT], ca_full[0]};
    end
  end

  // ============================================================
  // burst address generation
  logic [ARRAY_AW-1:0] addr_r;
  logic [ARRAY_AW-1:0] addr_inc;
  logic [ARRAY_AW-1:0] addr_nxt;
  logic [ARRAY_AW-1:0] addr_grp_end;
  logic [dpsr_pkg::GRP_W-1:0] grp_mask;
  logic [dpsr_pkg::GRP_W-1:0] grp_cnt_r;
  logic word_done;

  assign grp_mask = dpsr_pkg::GRP_W'((dpsr_pkg::WRAP_MIN_WORDS <<
                    cfg0_r[dpsr_pkg::CFG_WLEN_HI:dpsr_pkg::CFG_WLEN_LO]) - 7'h01);
  assign addr_inc = addr_r + ARRAY_AW'(1);  // wraps to zero past the top
  assign addr_grp_end = {addr_r[ARRAY_AW-1:dpsr_pkg::GRP_W], addr_r[dpsr_pkg::GRP_W-1:0] | grp_mask};
  assign word_done = fall && (state_r == dpsr_pkg::ST_RDATA || state_r == dpsr_pkg::ST_WDATA);

  // next word address for the current burst type
  always_comb begin
    if (linear_r) begin
      addr_nxt = addr_inc;
    end else if (hybrid_r && grp_cnt_r == grp_mask) begin
      addr_nxt = addr_grp_end + ARRAY_AW'(1);  // leave group at its next boundary
    end else begin
      addr_nxt = {addr_r[ARRAY_AW-1:dpsr_pkg::GRP_W],
                  (addr_r[dpsr_pkg::GRP_W-1:0] & ~grp_mask) | (addr_inc[dpsr_pkg::GRP_W-1:0] & grp_mask)};
    end
  end

  // address, wrap progress and burst type, one owner for the hybrid switch
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= '0;
      grp_cnt_r <= '0;
      linear_r <= 1'b0;
    end else if (ca_done) begin
      addr_r <= addr_full[ARRAY_AW-1:0];
      linear_r <= ca_full[dpsr_pkg::CA_BURST_BIT] != dpsr_pkg::BURST_WRAPPED;
      grp_cnt_r <= '0;
    end else if (word_done) begin
      addr_r <= addr_nxt;
      grp_cnt_r <= grp_cnt_r + dpsr_pkg::GRP_W'(1);
      if (hybrid_r && grp_cnt_r == grp_mask) begin
        linear_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // read word fetch
  logic arr_rd_req_r;
  logic [ARRAY_AW-1:0] arr_rd_addr_r;
  logic [15:0] rd_word_r;

  // array request at decode and after each word, register words from the mux
  always_ff @(posedge clk) begin
    if (rst) begin
      arr_rd_req_r <= 1'b0;
      arr_rd_addr_r <= '0;
      rd_word_r <= 16'h0000;
    end else begin
      arr_rd_req_r <= 1'b0;
      if (ca_done && ca_full[dpsr_pkg::CA_RW_BIT] && !ca_full[dpsr_pkg::CA_SPACE_BIT]) begin
        arr_rd_req_r <= 1'b1;
        arr_rd_addr_r <= addr_full[ARRAY_AW-1:0];
      end else if (word_done && is_read_r && !is_reg_r) begin
        arr_rd_req_r <= 1'b1;
        arr_rd_addr_r <= addr_nxt;
      end
      if (ca_done && ca_full[dpsr_pkg::CA_SPACE_BIT]) begin
        rd_word_r <= reg_word;
      end else if (arr_rd_valid) begin
        rd_word_r <= arr_rd_data;
      end
    end
  end

  // ============================================================
  // pin drivers
  logic [7:0] dq_out_r;
  logic dq_oe_r;
  logic read_write_data_strobe_out_r;
  logic read_write_data_strobe_oe_r;

  // strobe and data drive per phase
  always_ff @(posedge clk) begin
    if (rst || !selected) begin
      dq_out_r <= 8'h00;
      dq_oe_r <= 1'b0;
      read_write_data_strobe_out_r <= 1'b0;
      read_write_data_strobe_oe_r <= 1'b0;
    end else if (state_r == dpsr_pkg::ST_IDLE) begin
      read_write_data_strobe_out_r <= refresh_busy | cfg0_r[dpsr_pkg::CFG_FIXED_BIT];
      read_write_data_strobe_oe_r <= 1'b1;
    end else if (ca_done) begin
      read_write_data_strobe_out_r <= 1'b0;
      read_write_data_strobe_oe_r <= ca_full[dpsr_pkg::CA_RW_BIT];  // release for writes
    end else if (state_r == dpsr_pkg::ST_RDATA && rise) begin
      dq_out_r <= rd_word_r[15:8];  // high byte first
      dq_oe_r <= 1'b1;
      read_write_data_strobe_out_r <= 1'b1;
    end else if (state_r == dpsr_pkg::ST_RDATA && fall) begin
      dq_out_r <= rd_word_r[7:0];
      read_write_data_strobe_out_r <= 1'b0;
    end
  end

  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign read_write_data_strobe_out = read_write_data_strobe_out_r;
  assign read_write_data_strobe_oe = read_write_data_strobe_oe_r;

  // ============================================================
  // write capture, register writes and buffer push
  logic [7:0] byte_a_r;
  logic mask_a_r;
  logic push_r;
  logic [BW-1:0] push_data_r;
  logic ovf_r;
  logic busy_r;

  dpsr_buf_if #(.W(BW)) wbuf ();

  dpsr_buf #(.W(BW)) u_wbuf (
    .clk(clk),
    .rst(rst),
    .port(wbuf.store)
  );

  // first byte on rising, word completes on falling
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_a_r <= 8'h00;
      mask_a_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= '0;
    end else begin
      push_r <= 1'b0;
      if (rise && (state_r == dpsr_pkg::ST_WDATA || state_r == dpsr_pkg::ST_REGWR)) begin
        byte_a_r <= dq_s;
        mask_a_r <= read_write_data_strobe_s;
      end
      if (fall && state_r == dpsr_pkg::ST_WDATA) begin
        push_r <= 1'b1;
        push_data_r <= {addr_r, byte_a_r, dq_s, mask_a_r, read_write_data_strobe_s};  // mask high keeps array byte
      end
    end
  end

  // configuration registers, whole word, high byte first
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg0_r <= dpsr_pkg::CFG0_RST;
      cfg1_r <= dpsr_pkg::CFG1_RST;
    end else if (fall && state_r == dpsr_pkg::ST_REGWR && reg_sel_r[1]) begin
      if (reg_sel_r[0]) begin
        cfg1_r <= {byte_a_r, dq_s};
      end else begin
        cfg0_r <= {byte_a_r, dq_s};
      end
    end
  end

  // sticky overflow when a word meets a full buffer; set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      ovf_r <= (push_r & ~wbuf.push_ready) | (ovf_r & ~overflow_clear);
      busy_r <= state_r != dpsr_pkg::ST_IDLE;
    end
  end

  assign wbuf.push_valid = push_r;
  assign wbuf.push_data = push_data_r;
  assign wbuf.pop_ready = arr_wr_ready;
  assign arr_wr_valid = wbuf.pop_valid;
  assign arr_wr_addr = wbuf.pop_data[BW-1:18];
  assign arr_wr_data = wbuf.pop_data[17:2];
  assign arr_wr_mask = wbuf.pop_data[1:0];
  assign arr_rd_req = arr_rd_req_r;
  assign arr_rd_addr = arr_rd_addr_r;
  assign wr_overflow = ovf_r;
  assign busy = busy_r;
  assign config_register_first = cfg0_r;
  assign config_register_second = cfg1_r;
endmodule // dpsr_device

/* rtl/dpsr_pkg.sv */
// ============================================================
// shared constants for the pseudo-static dram bus slave
package dpsr_pkg;

  // ============================================================
  // command/address word layout
  localparam int CA_W = 48;
  localparam int CA_RW_BIT = 47;
  localparam int CA_SPACE_BIT = 46;
  localparam int CA_BURST_BIT = 45;
  localparam int CA_COL_W = 3;
  localparam int ROW_W = 29;
  localparam int ROW_REG_SEL_BIT = 8;
  localparam logic [2:0] CA_LAST_EDGE = 3'h5;
  localparam logic [2:0] CA_ROW_EDGE = 3'h3;
  localparam logic BURST_WRAPPED = 1'b0;

  // ============================================================
  // first configuration register fields and reset values
  localparam int CFG_LAT_HI = 7;
  localparam int CFG_LAT_LO = 4;
  localparam int CFG_FIXED_BIT = 3;
  localparam int CFG_HYBRID_BIT = 2;
  localparam int CFG_WLEN_HI = 1;
  localparam int CFG_WLEN_LO = 0;
  localparam logic [15:0] CFG0_RST = 16'h0043;
  localparam logic [15:0] CFG1_RST = 16'h0000;

  // ============================================================
  // wrap group sizing and synchroniser reset image
  localparam int GRP_W = 6;
  localparam logic [6:0] WRAP_MIN_WORDS = 7'h08;
  localparam logic [10:0] SYNC_RST = 11'h200;

  // ============================================================
  // transaction states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CA    = 3'b001,
    ST_LAT   = 3'b010,
    ST_RDATA = 3'b011,
    ST_WDATA = 3'b100,
    ST_REGWR = 3'b101,
    ST_HOLD  = 3'b110
  } dpsr_state_type;

endpackage

/* rtl/dpsr_buf_if.sv */
`timescale 1ns/1ns
// ============================================================
// valid/ready carrier between the slave and its write buffer
interface dpsr_buf_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport fill (output push_valid, output push_data, input push_ready);
  modport store (input push_valid, input push_data, output push_ready,
                 output pop_valid, output pop_data, input pop_ready);
  modport drain (input pop_valid, input pop_data, output pop_ready);
endinterface

/* rtl/dpsr_buf.sv */
`timescale 1ns/1ns
// ============================================================
// two-entry buffer, head always in the first slot
module dpsr_buf #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  dpsr_buf_if.store port
);
  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  logic head_v_r;
  logic tail_v_r;
  logic push;
  logic pop;

  // handshake terms
  assign push = port.push_valid & ~tail_v_r;
  assign pop = head_v_r & port.pop_ready;
  assign port.push_ready = ~tail_v_r;  // full when both slots hold a word
  assign port.pop_valid = head_v_r;
  assign port.pop_data = head_r;

  // slot movement
  always_ff @(posedge clk) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
    end else if (pop) begin
      if (tail_v_r) begin
        head_r <= tail_r;  // push impossible while tail is full
        tail_v_r <= 1'b0;
      end else if (push) begin
        head_r <= port.push_data;
      end else begin
        head_v_r <= 1'b0;
      end
    end else if (push) begin
      if (!head_v_r) begin
        head_r <= port.push_data;
        head_v_r <= 1'b1;
      end else begin
        tail_r <= port.push_data;
        tail_v_r <= 1'b1;
      end
    end
  end
endmodule // dpsr_buf

/* bench/dpsr_device_properties.sv */
`timescale 1ns/1ns
// ============================================================
// port checks for the bus slave
module dpsr_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic refresh_busy,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic read_write_data_strobe_out,
  input wire logic read_write_data_strobe_oe,
  input wire logic arr_wr_valid,
  input wire logic arr_wr_ready,
  input wire logic [15:0] arr_wr_data,
  input wire logic arr_rd_req,
  input wire logic wr_overflow,
  input wire logic busy,
  input wire logic [15:0] config_register_first
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ============================================================
  // strobe, release and stream checks
  chk_ca_strobe: assert property ($fell(cs_n) |-> ##[3:10] read_write_data_strobe_oe)
    else $error("strobe not driven after select");
  chk_latency_flag: assert property (
    $rose(read_write_data_strobe_oe) |-> read_write_data_strobe_out == (refresh_busy | config_register_first[3]))
    else $error("wrong latency flag");
  chk_release_lines: assert property ($rose(cs_n) |-> ##[1:6] (!dq_oe && !read_write_data_strobe_oe))
    else $error("lines not released");
  chk_idle_state: assert property (cs_n [*8] |-> !busy)
    else $error("busy while deselected");
  chk_write_release: assert property (arr_wr_valid |-> !read_write_data_strobe_oe)
    else $error("strobe driven during write");
  chk_strobe_follow: assert property (
    dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(read_write_data_strobe_out))
    else $error("strobe did not follow data");
  chk_rd_spacing: assert property (arr_rd_req |=> !arr_rd_req [*3])
    else $error("read requests too close");
  chk_wr_hold: assert property (arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr_data))
    else $error("stalled word changed");
  cover property ($rose(dq_oe));
  cover property (arr_wr_valid && arr_wr_ready);
  cover property ($rose(wr_overflow));
endmodule // dpsr_checker

/* bench/dpsr_host_model.sv */
`timescale 1ns/1ns
// ============================================================
// bus master model: frames, latency, masks, read capture
module dpsr_host_model (
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic strobe_out,
  input wire logic strobe_oe,
  output logic cs_n,
  output logic link_clock,
  output logic [7:0] dq_w,
  output logic strobe_w
);
  logic [7:0] dq_h = 8'h00;
  logic [7:0] idle_pat = 8'h5A;
  logic [7:0] byte_a = 8'h00;
  logic dq_oe_h = 1'b0;
  logic mask_h = 1'b0;
  logic mask_oe = 1'b0;
  logic rd_phase = 1'b0;
  logic lat_flag = 1'b0;
  logic [15:0] wd [0:15];
  logic [1:0] wm [0:15];
  logic [15:0] rd [0:15];
  int lat = 4;
  int nrd = 0;
  initial begin
    cs_n = 1'b1;
    link_clock = 1'b0;
  end
  // released lines show a pattern that flips every 37 ns
  always #37 idle_pat = ~idle_pat;
  // wire levels from both parties' enables
  assign dq_w = dq_oe ? dq_out : (dq_oe_h ? dq_h : idle_pat);
  assign strobe_w = strobe_oe ? strobe_out : (mask_oe ? mask_h : idle_pat[0]);
  // read bytes taken on strobe edges
  // short wait so data launched with the strobe has settled
  always @(posedge strobe_w) begin
    #5;
    if (rd_phase) byte_a = dq_w;
  end
  always @(negedge strobe_w) begin
    #5;
    if (rd_phase) begin
      rd[nrd] = {byte_a, dq_w};
      nrd++;
    end
  end
  // one half period, data centred on the edge
  task automatic half(input logic [7:0] d, input logic m);
    dq_h = d;
    mask_h = m;
    #100;
    link_clock = ~link_clock;
    #100;
  endtask
  // one whole frame
  task automatic xfer(input logic [47:0] cmd, input int n);
    int k;
    int cycles;
    logic wr;
    wr = !cmd[47];
    nrd = 0;
    #13;
    cs_n = 1'b0; // clock idle low at selection
    #400;
    dq_oe_h = 1'b1;
    for (k = 0; k < 6; k++) half(cmd[47 - 8 * k -: 8], 1'b0);
    lat_flag = strobe_w;
    cycles = (wr && cmd[46]) ? 0 : lat * (lat_flag ? 2 : 1);
    dq_oe_h = wr;
    for (k = 0; k < 2 * cycles; k++) begin
      half(8'h00, 1'b0);
      mask_oe = wr; // low preamble after release
    end
    rd_phase = !wr;
    for (k = 0; k < n; k++) begin
      half(wd[k][15:8], wm[k][1]);
      half(wd[k][7:0], wm[k][0]);
    end
    #200;
    rd_phase = 1'b0;
    cs_n = 1'b1; // frame ends with clock idle
    dq_oe_h = 1'b0;
    mask_oe = 1'b0;
    #400;
  endtask
  // clock runs while deselected
  task automatic idle_clk(input int n);
    int k;
    for (k = 0; k < 2 * n; k++) half(8'h00, 1'b0);
  endtask
endmodule // dpsr_host_model

/* bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] ID0 = 16'h2468; // arbitrary value
  localparam logic [15:0] ID1 = 16'h0A0B; // arbitrary value
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic refresh_busy = 1'b0;
  logic overflow_clear = 1'b0;
  logic arr_wr_ready = 1'b0;
  logic arr_rd_valid = 1'b0;
  logic [15:0] arr_rd_data = 16'h0000;
  logic stall = 1'b0;
  logic hyb = 1'b0;
  int grp = 64;
  logic cs_n, link_clock, dq_oe, strobe_w, strobe_out, strobe_oe, arr_wr_valid, arr_rd_req, wr_overflow, busy;
  logic [7:0] dq_w, dq_out, arr_wr_addr, arr_rd_addr;
  logic [15:0] arr_wr_data, cfg0, cfg1;
  logic [1:0] arr_wr_mask;
  logic [15:0] mem [0:255];
  logic [15:0] ref_mem [0:255];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // rows: start word, length, linear, first-word mask
  int r_st [0:4] = '{60, 254, 62, 20, 13};
  int r_n [0:4] = '{6, 4, 4, 3, 10};
  logic r_lin [0:4] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [1:0] r_m [0:4] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h0};

  initial begin
    forever #25 clk = ~clk;
  end

  dpsr_device #(.ARRAY_AW(8), .ID0_VALUE(ID0), .ID1_VALUE(ID1)) i_dpsr_device (
    .clk(clk), .rst(rst), .link_clock(link_clock), .cs_n(cs_n), .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe),
    .read_write_data_strobe_in(strobe_w), .read_write_data_strobe_out(strobe_out),
    .read_write_data_strobe_oe(strobe_oe), .refresh_busy(refresh_busy), .arr_wr_valid(arr_wr_valid),
    .arr_wr_ready(arr_wr_ready), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data), .arr_wr_mask(arr_wr_mask),
    .arr_rd_req(arr_rd_req), .arr_rd_addr(arr_rd_addr), .arr_rd_valid(arr_rd_valid), .arr_rd_data(arr_rd_data),
    .overflow_clear(overflow_clear), .wr_overflow(wr_overflow), .busy(busy), .config_register_first(cfg0),
    .config_register_second(cfg1));

  dpsr_host_model host (.dq_out(dq_out), .dq_oe(dq_oe), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
    .cs_n(cs_n), .link_clock(link_clock), .dq_w(dq_w), .strobe_w(strobe_w));

  // array side: stalls one cycle in four, every cycle while stall is high, answers reads next cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    arr_wr_ready <= !stall && (cyc[1:0] != 2'h0);
    arr_rd_valid <= arr_rd_req;
    arr_rd_data <= mem[arr_rd_addr];
    if (arr_wr_valid && arr_wr_ready && !arr_wr_mask[1]) mem[arr_wr_addr][15:8] <= arr_wr_data[15:8];
    if (arr_wr_valid && arr_wr_ready && !arr_wr_mask[0]) mem[arr_wr_addr][7:0] <= arr_wr_data[7:0];
    if (cyc == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  function automatic logic [47:0] mk_cmd(input logic rw, input logic lin, input logic [7:0] a);
    return {rw, 1'b0, lin, 24'h000000, a[7:3], 13'h0000, a[2:0]};
  endfunction
  function automatic logic [47:0] reg_cmd(input logic rw, input logic [1:0] sel);
    return {rw, 2'h3, 20'h00000, sel[1], 23'h000000, sel[0]};
  endfunction
  // word address of beat i under wrapped, hybrid or linear order
  function automatic logic [7:0] adr(input int st, input int i, input logic lin);
    int b;
    b = st - st % grp;
    if (lin || (hyb && i >= grp)) return 8'(lin ? st + i : b + i);
    return 8'(b + (st % grp + i) % grp);
  endfunction

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (e !== s) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // write one row, then read it back when rd_back is set
  task automatic burst(input int r, input logic rd_back);
    int i;
    logic [7:0] a;
    for (i = 0; i < r_n[r]; i++) begin
      a = adr(r_st[r], i, r_lin[r]);
      host.wd[i] = 16'(16'h1D2B * (r + 3) + i * 16'h0907);
      host.wm[i] = (i == 0) ? r_m[r] : 2'h0;
      if (!host.wm[i][1]) ref_mem[a][15:8] = host.wd[i][15:8];
      if (!host.wm[i][0]) ref_mem[a][7:0] = host.wd[i][7:0];
    end
    host.xfer(mk_cmd(1'b0, r_lin[r], 8'(r_st[r])), r_n[r]);
    if (rd_back) begin
      host.xfer(mk_cmd(1'b1, r_lin[r], 8'(r_st[r])), r_n[r]);
      check("read count", 16'(r_n[r]), 16'(host.nrd));
      for (i = 0; i < r_n[r]; i++) check("read word", ref_mem[adr(r_st[r], i, r_lin[r])], host.rd[i]);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'(i * 16'h0107);
      ref_mem[i] = 16'(i * 16'h0107);
    end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("cfg0 reset", 16'h0043, cfg0);
    check("cfg1 reset", 16'h0000, cfg1);
    check("idle outputs", 16'h0000, 16'({dq_oe, strobe_oe, busy, wr_overflow}));
    host.idle_clk(4);
    check("busy idle clock", 16'h0000, 16'(busy));
    for (int r = 0; r < 4; r++) burst(r, 1'b1);
    host.xfer(reg_cmd(1'b1, 2'h0), 1);
    check("id0 read", ID0, host.rd[0]);
    host.xfer(reg_cmd(1'b1, 2'h1), 1);
    check("id1 read", ID1, host.rd[0]);
    host.xfer(reg_cmd(1'b1, 2'h2), 1);
    check("cfg0 read", 16'h0043, host.rd[0]);
    @(posedge clk);
    refresh_busy <= 1'b1;
    burst(0, 1'b1);
    check("long latency flag", 16'h0001, 16'(host.lat_flag));
    @(posedge clk);
    refresh_busy <= 1'b0;
    host.wd[0] = 16'h001C;
    host.xfer(reg_cmd(1'b0, 2'h2), 1);
    check("cfg0 write", 16'h001C, cfg0);
    host.lat = 1;
    hyb = 1'b1;
    grp = 8;
    burst(4, 1'b1);
    check("fixed latency flag", 16'h0001, 16'(host.lat_flag));
    @(posedge clk);
    stall <= 1'b1;
    burst(1, 1'b0);
    check("overflow set", 16'h0001, 16'(wr_overflow));
    @(posedge clk);
    stall <= 1'b0;
    overflow_clear <= 1'b1;
    @(posedge clk);
    overflow_clear <= 1'b0;
    repeat (2) @(posedge clk);
    check("overflow clear", 16'h0000, 16'(wr_overflow));
    final_report();
  end
endmodule // testbench

bind dpsr_device dpsr_checker i_dpsr_checker (.clk(clk), .rst(rst), .cs_n(cs_n), .refresh_busy(refresh_busy),
  .dq_out(dq_out), .dq_oe(dq_oe), .read_write_data_strobe_out(read_write_data_strobe_out),
  .read_write_data_strobe_oe(read_write_data_strobe_oe), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
  .arr_wr_data(arr_wr_data), .arr_rd_req(arr_rd_req), .wr_overflow(wr_overflow), .busy(busy),
  .config_register_first(config_register_first));
